//--- hdl/rtpt_defines.svh
// constants for the real-time counter and periodic timer block
// assumes inclusion by bare name from the package and the top module
`ifndef RTPT_DEFINES_SVH
`define RTPT_DEFINES_SVH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define RTPT_CNT_W        16
`define RTPT_PRE_W        15
`define RTPT_SEL_W        4
`define RTPT_ERR_W        7
`define RTPT_ACC_W        20
`define RTPT_ULPDIV_W     5
`define RTPT_PIT_EVT_N    8

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RTPT_CNT_RST      16'h0000
`define RTPT_PRE_RST      15'h0000
`define RTPT_ACC_RST      20'h00000

// ------------------------------------------------------------
// field codes and positions
// ------------------------------------------------------------
`define RTPT_PIT_OFF      4'h0
`define RTPT_PIT_MAXCODE  4'he
`define RTPT_PIT_EVT0_BIT 12
`define RTPT_STEP_SKIP    15'h0002
`define RTPT_STEP_NORM    15'h0001
`define RTPT_STEP_HOLD    15'h0000

`endif

//--- hdl/rtpt_pkg.sv
// types shared by the real-time counter and periodic timer block
// assumes the defines header sits beside it
`include "rtpt_defines.svh"

package rtpt_pkg;

	// ------------------------------------------------------------
	// slow clock sources
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RTPT_SRC_XTAL   = 2'b00,
		RTPT_SRC_EXTCLK = 2'b01,
		RTPT_SRC_ULP    = 2'b10,
		RTPT_SRC_ULP32  = 2'b11
	} rtpt_src_t;

	// ------------------------------------------------------------
	// complete block state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0]                    sync1;
		logic [3:0]                    sync2;
		logic                          ulp_prev;
		logic [`RTPT_ULPDIV_W-1:0]     ulp_div;
		logic                          slow_prev;
		logic [`RTPT_PRE_W-1:0]        pre;
		logic [`RTPT_ACC_W-1:0]        acc;
		logic [`RTPT_CNT_W-1:0]        cnt;
		logic                          ovf_flag;
		logic                          cmp_flag;
		logic                          pit_flag;
		logic                          ovf_evt;
		logic                          cmp_evt;
		logic                          pit_out;
		logic [`RTPT_PIT_EVT_N-1:0]    pit_evt;
	} rtpt_state_t;

endpackage : rtpt_pkg

//--- hdl/rtpt_top.sv
// real-time counter and periodic interrupt timer, one shared prescaler
// assumes all config inputs come from logic on i_core_clk; clock pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "rtpt_defines.svh"

// Contract
// RULE1: sixteen-bit counter on prescaled ticks, compared to period and compare values
// RULE2: compare flag and event on first tick after counter equals compare
// RULE3: overflow flag and event on first tick after counter equals period; reload zero
// RULE4: slow clock chosen from crystal, external clock, low-power oscillator, oscillator/32
// RULE5: selected clock divided by fifteen-bit prescaler before reaching counter
// RULE6: correction skips or inserts prescaler counts, one ppm granularity
// RULE7: periodic timer runs independent of counter enable
// RULE8: periodic interrupt every power of two 4..32768; events 64..8192
// RULE9: core clock at least four times the slow clock for valid reads
// RULE10: software sets oscillator then source select before enabling functions
// RULE11: software loads compare/period, interrupt enables, then prescaler with enable
// RULE12: software checks busy flags before writing, also at first configuration
// RULE13: counter enabled by enable bit one, disabled by zero
// RULE14: software sets slow clock, periodic enable, then period with timer enable
// RULE15: periodic timer enabled by its bit one, disabled by zero
// RULE16: one shared prescaler; independent tick rate and periodic interval selections
// RULE17: prescaler stopped when both enables are zero, counts otherwise
// RULE18: first tick and first periodic interrupt may come anywhere within a period
// RULE19: periodic output toggles every half period after first interrupt
// RULE20: periodic output follows one prescaler bit; sixteen cycles uses bit three
// RULE21: prescaler code k divides slow clock by two to the power k
// RULE22: overflow and compare events last exactly one slow clock cycle
// RULE23: eight half-duty periodic events, periods 8192 down to 64
// RULE24: interrupt request while flag and enable both set, held until cleared
// RULE25: counter increments by one per tick, holds while disabled
module rtpt_top
	import rtpt_pkg::*;
(
	input  wire logic                        i_core_clk,
	input  wire logic                        i_reset,
	input  wire logic                        i_crystal_pin_one,
	input  wire logic                        i_ext_clock_pin,
	input  wire logic                        i_ultra_low_power_oscillator,
	input  wire rtpt_pkg::rtpt_src_t         i_slow_clock_source_select,
	input  wire logic                        i_counter_enable_bit,
	input  wire logic [`RTPT_SEL_W-1:0]      i_prescaler_select,
	input  wire logic                        i_crystal_correction_enable,
	input  wire logic                        i_calib_sign,
	input  wire logic [`RTPT_ERR_W-1:0]      i_calib_error,
	input  wire logic [`RTPT_CNT_W-1:0]      i_counter_period_value,
	input  wire logic [`RTPT_CNT_W-1:0]      i_compare_value,
	input  wire logic                        i_counter_overflow_irq_enable,
	input  wire logic                        i_compare_match_irq_enable,
	input  wire logic                        i_counter_overflow_clear,
	input  wire logic                        i_compare_match_clear,
	input  wire logic                        i_periodic_timer_enable_bit,
	input  wire logic [`RTPT_SEL_W-1:0]      i_periodic_period_select,
	input  wire logic                        i_periodic_irq_enable,
	input  wire logic                        i_periodic_flag_clear,
	output logic [`RTPT_CNT_W-1:0]           o_count,
	output logic                             o_counter_overflow_flag,
	output logic                             o_compare_match_flag,
	output logic                             o_periodic_flag,
	output logic                             o_counter_irq,
	output logic                             o_periodic_irq,
	output logic                             o_counter_overflow_event,
	output logic                             o_compare_match_event,
	output logic                             o_periodic_out,
	output logic [`RTPT_PIT_EVT_N-1:0]       o_periodic_events
);
	import rtpt_pkg::*;

	rtpt_state_t q;
	rtpt_state_t d;

	logic                      slow_lvl;
	logic                      slow_tick;
	logic                      pre_run;
	logic [`RTPT_ACC_W:0]      acc_sum;
	logic                      corr_now;
	logic [`RTPT_PRE_W-1:0]    step;
	logic [`RTPT_PRE_W:0]      mask_w;
	logic [`RTPT_PRE_W-1:0]    mask;
	logic                      cnt_tick;
	logic                      run_en;
	logic                      pit_en;
	logic                      ovf_set;
	logic                      cmp_set;
	logic                      pit_set;
	logic [`RTPT_PRE_W:0]      low_sum;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		d = q;
		slow_lvl = 1'b0;
		run_en = i_counter_enable_bit;
		pit_en = i_periodic_timer_enable_bit;
		ovf_set = 1'b0;
		cmp_set = 1'b0;
		pit_set = 1'b0;

		// pin synchronisers, first stage read only by second
		d.sync1 = {1'b0, i_ultra_low_power_oscillator, i_ext_clock_pin, i_crystal_pin_one};
		d.sync2 = q.sync1;

		// oscillator divided by thirty-two
		d.ulp_prev = q.sync2[2];
		if (q.sync2[2] && !q.ulp_prev)
		begin
			d.ulp_div = q.ulp_div + `RTPT_ULPDIV_W'(1);
		end

		// source selection
		unique case (i_slow_clock_source_select)                    // [RULE4]
			RTPT_SRC_XTAL:   slow_lvl = q.sync2[0];
			RTPT_SRC_EXTCLK: slow_lvl = q.sync2[1];
			RTPT_SRC_ULP:    slow_lvl = q.sync2[2];
			RTPT_SRC_ULP32:  slow_lvl = q.ulp_div[`RTPT_ULPDIV_W-1];
		endcase
		d.slow_prev = slow_lvl;
		slow_tick = slow_lvl && !q.slow_prev;

		// shared prescaler with crystal correction
		pre_run = run_en || pit_en;                                 // [RULE17] [RULE7]
		acc_sum = {1'b0, q.acc} + {{(`RTPT_ACC_W-`RTPT_ERR_W+1){1'b0}}, i_calib_error};
		corr_now = i_crystal_correction_enable && acc_sum[`RTPT_ACC_W];
		step = `RTPT_STEP_NORM;
		if (corr_now)
		begin
			step = i_calib_sign ? `RTPT_STEP_SKIP : `RTPT_STEP_HOLD;  // [RULE6]
		end
		if (pre_run && slow_tick)
		begin
			d.pre = q.pre + step;                                   // [RULE5] [RULE16]
			if (i_crystal_correction_enable)
			begin
				d.acc = acc_sum[`RTPT_ACC_W-1:0];                   // [RULE6]
			end
		end

		// counter tick from prescaler wrap of low k bits
		mask_w = (`RTPT_PRE_W+1)'(1) << i_prescaler_select;
		mask_w = mask_w - (`RTPT_PRE_W+1)'(1);
		mask = mask_w[`RTPT_PRE_W-1:0];
		// carry out of the low k bits, so a skipped count still ticks
		low_sum = {1'b0, q.pre & mask} + {1'b0, step};
		cnt_tick = pre_run && slow_tick && (low_sum > {1'b0, mask}); // [RULE21] [RULE18] [RULE6]

		// overflow and compare events held for one slow cycle
		if (slow_tick)
		begin
			d.ovf_evt = 1'b0;                                       // [RULE22]
			d.cmp_evt = 1'b0;
		end

		// real-time counter
		if (run_en && cnt_tick)                                     // [RULE13] [RULE25]
		begin
			if (q.cnt == i_compare_value)                           // [RULE1]
			begin
				d.cmp_flag = 1'b1;                                  // [RULE2]
				cmp_set = 1'b1;
				d.cmp_evt = 1'b1;                                   // [RULE22]
			end
			if (q.cnt == i_counter_period_value)
			begin
				d.cnt = `RTPT_CNT_RST;                              // [RULE3]
				d.ovf_flag = 1'b1;
				d.ovf_evt = 1'b1;
				ovf_set = 1'b1;
			end
			else
			begin
				d.cnt = q.cnt + `RTPT_CNT_W'(1);                    // [RULE25]
			end
		end
		else if (!run_en)
		begin
			d.ovf_evt = 1'b0;
			d.cmp_evt = 1'b0;
		end

		// periodic output follows selected prescaler bit
		d.pit_out = 1'b0;
		if (pit_en && (i_periodic_period_select != `RTPT_PIT_OFF)
			&& (i_periodic_period_select <= `RTPT_PIT_MAXCODE))     // [RULE15]
		begin
			d.pit_out = d.pre[i_periodic_period_select];            // [RULE20] [RULE19] [RULE8]
		end
		pit_set = d.pit_out && !q.pit_out;
		if (pit_set)
		begin
			d.pit_flag = 1'b1;                                      // [RULE8] [RULE18]
		end

		// periodic events, half duty, 8192 down to 64
		for (int i = 0; i < `RTPT_PIT_EVT_N; i++)
		begin
			d.pit_evt[i] = pit_en && d.pre[`RTPT_PIT_EVT0_BIT - i]; // [RULE23]
		end

		// flag clears, a same-cycle set wins
		if (i_counter_overflow_clear && !ovf_set)
		begin
			d.ovf_flag = 1'b0;                                      // [RULE24]
		end
		if (i_compare_match_clear && !cmp_set)
		begin
			d.cmp_flag = 1'b0;
		end
		if (i_periodic_flag_clear && !pit_set)
		begin
			d.pit_flag = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_count                  = q.cnt;
	assign o_counter_overflow_flag  = q.ovf_flag;
	assign o_compare_match_flag     = q.cmp_flag;
	assign o_periodic_flag          = q.pit_flag;
	assign o_counter_irq            = (q.ovf_flag && i_counter_overflow_irq_enable)
		|| (q.cmp_flag && i_compare_match_irq_enable);             // [RULE24]
	assign o_periodic_irq           = q.pit_flag && i_periodic_irq_enable; // [RULE24]
	assign o_counter_overflow_event = q.ovf_evt;
	assign o_compare_match_event    = q.cmp_evt;
	assign o_periodic_out           = q.pit_out;
	assign o_periodic_events        = q.pit_evt;

endmodule : rtpt_top

`default_nettype wire

//--- bench/rtpt_properties.sv
// port checker for the counter and periodic timer block
// assumes it is bound to rtpt_top with one core clock
`timescale 1ns/1ps
`default_nettype none
`include "rtpt_defines.svh"
module rtpt_properties (
	input  wire logic                    i_core_clk,
	input  wire logic                    i_reset,
	input  wire logic                    i_counter_enable_bit,
	input  wire logic                    i_counter_overflow_irq_enable,
	input  wire logic                    i_compare_match_irq_enable,
	input  wire logic [`RTPT_SEL_W-1:0]  i_periodic_period_select,
	input  wire logic                    i_periodic_irq_enable,
	input  wire logic [`RTPT_CNT_W-1:0]  o_count,
	input  wire logic                    o_counter_overflow_flag,
	input  wire logic                    o_compare_match_flag,
	input  wire logic                    o_periodic_flag,
	input  wire logic                    o_counter_irq,
	input  wire logic                    o_periodic_irq,
	input  wire logic                    o_counter_overflow_event,
	input  wire logic                    o_compare_match_event,
	input  wire logic                    o_periodic_out
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	sequence s_ovf_rise; $rose(o_counter_overflow_event) ##0 i_counter_enable_bit; endsequence
	sequence s_ovf_hold; (o_counter_overflow_event || !i_counter_enable_bit)[*2]; endsequence
	a_counter_irq: assert property (
		o_counter_irq == ((o_counter_overflow_flag && i_counter_overflow_irq_enable)
		|| (o_compare_match_flag && i_compare_match_irq_enable))) else $error("counter irq wrong");
	a_periodic_irq: assert property (
		o_periodic_irq == (o_periodic_flag && i_periodic_irq_enable)) else $error("pit irq wrong");
	a_count_hold: assert property (
		!i_counter_enable_bit[*3] |-> $stable(o_count)) else $error("count moved while off");
	a_count_step: assert property (
		o_count != $past(o_count) |-> o_count == $past(o_count) + 16'h0001 || o_count == 16'h0000)
		else $error("count step wrong");
	a_wrap_ovf: assert property (
		o_count == 16'h0000 && $past(o_count) != 16'h0000 |->
		o_counter_overflow_flag || $past(o_counter_overflow_flag)) else $error("wrap without ovf");
	a_evt_off: assert property (
		!i_counter_enable_bit[*2] |-> !o_counter_overflow_event && !o_compare_match_event)
		else $error("event while off");
	a_ovf_evt_len: assert property (
		s_ovf_rise |=> s_ovf_hold) else $error("ovf event too short");
	a_ovf_evt_end: assert property (
		$rose(o_counter_overflow_event) |-> ##[1:400] !o_counter_overflow_event)
		else $error("ovf event too long");
	a_pit_off: assert property (
		(i_periodic_period_select == 4'h0 || i_periodic_period_select == 4'hf)[*2] |->
		!o_periodic_out) else $error("pit out while off");
	a_pit_flag: assert property (
		$rose(o_periodic_out) |-> ##[0:1] o_periodic_flag) else $error("pit flag missing");
endmodule : rtpt_properties
bind rtpt_top rtpt_properties chk_u (.i_core_clk, .i_reset, .i_counter_enable_bit,
	.i_counter_overflow_irq_enable, .i_compare_match_irq_enable, .i_periodic_period_select,
	.i_periodic_irq_enable, .o_count, .o_counter_overflow_flag, .o_compare_match_flag,
	.o_periodic_flag, .o_counter_irq, .o_periodic_irq, .o_counter_overflow_event,
	.o_compare_match_event, .o_periodic_out);
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the counter and periodic timer block
// assumes design and checker compiled first; slow pins made here
`timescale 1ns/1ps
`default_nettype none
`include "rtpt_defines.svh"
module tb;
	import rtpt_pkg::*;
	logic        clk = 0, rst = 1, xtal = 0, ext = 0, ulp = 0, cen = 0, oen = 0, cmpen = 0;
	logic        oclr = 0, cclr = 0, pen = 0, pien = 0, pclr = 0, corr = 0, csign = 0;
	logic [6:0]  cerr = 7'h00;
	logic [3:0]  psel = 4'h0, pcode = 4'h0, probe;
	logic [15:0] counter_period_value = 16'hffff, cmpv = 16'h0000, cnt;
	logic        ovf_f, cmp_f, pit_f, cirq, pirq, ovf_e, cmp_e, pout;
	logic [7:0]  pev;
	rtpt_src_t   src = RTPT_SRC_XTAL;
	int          cyc = 0, n_errors = 0, compares = 0;
	assign probe = {pev[7], pout, cmp_e, ovf_e};
	rtpt_top dut_u (.i_core_clk(clk), .i_reset(rst), .i_crystal_pin_one(xtal),
		.i_ext_clock_pin(ext), .i_ultra_low_power_oscillator(ulp),
		.i_slow_clock_source_select(src), .i_counter_enable_bit(cen), .i_prescaler_select(psel),
		.i_crystal_correction_enable(corr), .i_calib_sign(csign), .i_calib_error(cerr),
		.i_counter_period_value(counter_period_value), .i_compare_value(cmpv), .i_counter_overflow_irq_enable(oen),
		.i_compare_match_irq_enable(cmpen), .i_counter_overflow_clear(oclr),
		.i_compare_match_clear(cclr), .i_periodic_timer_enable_bit(pen),
		.i_periodic_period_select(pcode), .i_periodic_irq_enable(pien),
		.i_periodic_flag_clear(pclr), .o_count(cnt), .o_counter_overflow_flag(ovf_f),
		.o_compare_match_flag(cmp_f), .o_periodic_flag(pit_f), .o_counter_irq(cirq),
		.o_periodic_irq(pirq), .o_counter_overflow_event(ovf_e), .o_compare_match_event(cmp_e),
		.o_periodic_out(pout), .o_periodic_events(pev));
	initial forever #50 clk = ~clk;
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		#10;
		if (cyc % 2 == 0) xtal = ~xtal;
		if (cyc % 3 == 0) ext = ~ext;
		if (cyc % 4 == 0) ulp = ~ulp;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask : step
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : check
	task automatic rise(input int idx, output int t);
		logic pv;
		t = -1;
		pv = probe[idx];
		for (int k = 0; k < 3000 && t < 0; k++)
		begin
			step(1);
			if (probe[idx] === 1'b1 && pv !== 1'b1) t = cyc;
			pv = probe[idx];
		end
		check("edge seen", t >= 0, 1);
	endtask : rise
	task automatic do_reset;
		rst = 1;
		step(10);
		rst = 0;
	endtask : do_reset
	task automatic stop_test;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	task automatic t_rate;
		rtpt_src_t   s [5] = '{RTPT_SRC_XTAL, RTPT_SRC_EXTCLK, RTPT_SRC_ULP, RTPT_SRC_ULP32,
			RTPT_SRC_XTAL};
		int          k [5] = '{0, 0, 0, 0, 2};
		int          e [5] = '{256, 171, 128, 4, 64};
		logic [15:0] c0;
		for (int i = 0; i < 5; i++)
		begin
			src = s[i];
			psel = k[i];
			cen = 1;
			do_reset;
			step(10);
			c0 = cnt;
			step(1024);
			check("tick rate", cnt - c0 + 1 >= e[i] && cnt - c0 <= e[i] + 1, 1);
			cen = 0;
			step(4);
			c0 = cnt;
			step(40);
			check("count hold", cnt, c0);
		end
	endtask : t_rate
	task automatic t_ovf;
		int t1, t2, t3, t4;
		src = RTPT_SRC_XTAL;
		counter_period_value = 16'h0005;
		cmpv = 16'h0003;
		oen = 1;
		cmpen = 1;
		psel = 4'h0;
		cen = 1;
		do_reset;
		rise(0, t1);
		rise(0, t2);
		check("ovf spacing", t2 - t1, 24);
		rise(1, t3);
		rise(0, t4);
		check("cmp to ovf", t4 - t3, 8);
		step(2);
		check("wrap", cnt, 16'h0000);
		check("flags", {ovf_f, cmp_f, cirq}, 3'b111);
		oclr = 1;
		step(1);
		oclr = 0;
		step(1);
		check("ovf clear", {ovf_f, cirq}, 2'b01);
		cclr = 1;
		step(1);
		cclr = 0;
		step(1);
		check("cmp clear", {cmp_f, cirq}, 2'b00);
		cen = 0;
		step(30);
		check("off event", {ovf_e, cmp_e}, 2'b00);
	endtask : t_ovf
	task automatic t_corr;
		int n [2];
		src = RTPT_SRC_XTAL;
		counter_period_value = 16'hffff;
		cerr = 7'h7f;
		csign = 1'b0;
		psel = 4'h0;
		cen = 1;
		for (int i = 0; i < 2; i++)
		begin
			corr = (i == 1);
			while (cyc % 4 != 0)
				step(1);
			do_reset;
			step(34000);
			n[i] = cnt;
		end
		check("correction", n[0] - n[1], 1);
		corr = 0;
		cen = 0;
	endtask : t_corr
	task automatic t_pit;
		int t1, t2;
		pien = 1;
		pcode = 4'h1;
		pen = 1;
		do_reset;
		for (int c = 1; c < 5; c++)
		begin
			pcode = c;
			rise(2, t1);
			rise(2, t2);
			check("pit period", t2 - t1, 4 << (c + 1));
		end
		step(63);
		check("pit high half", pout, 1'b1);
		step(1);
		check("pit low half", pout, 1'b0);
		rise(3, t1);
		rise(3, t2);
		check("event period", t2 - t1, 256);
		check("pit irq", {pit_f, pirq, cnt}, {2'b11, 16'h0000});
		pcode = 4'h0;
		step(4);
		pclr = 1;
		step(1);
		pclr = 0;
		step(1);
		check("pit off", {pout, pit_f, pirq}, 3'b000);
		pen = 0;
		step(4);
		check("events off", pev, 8'h00);
	endtask : t_pit
	initial
	begin
		t_rate;
		t_ovf;
		t_corr;
		t_pit;
		stop_test;
	end
	initial
	begin
		repeat (90000) @(posedge clk);
		n_errors++;
		stop_test;
	end
endmodule : tb
`default_nettype wire
